/* inc/alzc_map.vh */
// Register map, field positions and reset values of the light zone comparator
`ifndef ALZC_MAP_VH
`define ALZC_MAP_VH

// ==========================================================================
// Register offsets
`define ALZC_ADDR_LEVEL_ENABLE     8'h2f
`define ALZC_ADDR_ZONE_STATUS      8'h31
`define ALZC_ADDR_L2_THRESHOLD     8'h32
`define ALZC_ADDR_L2_HYSTERESIS    8'h33
`define ALZC_ADDR_L3_THRESHOLD     8'h34
`define ALZC_ADDR_L3_HYSTERESIS    8'h35

// ==========================================================================
// Field positions
`define ALZC_BIT_L2                0
`define ALZC_BIT_L3                1
`define ALZC_BIT_L4                2
`define ALZC_BIT_L5                3
`define ALZC_ENABLE_MSB            3

// ==========================================================================
// Reset values
`define ALZC_RST_BYTE              8'h00
`define ALZC_RST_ENABLE            4'h0
`define ALZC_RST_FLAGS             4'h0

// ==========================================================================
// Zone codes
`define ALZC_ZONE_DAYLIGHT         3'h1
`define ALZC_ZONE_BRIGHT           3'h2
`define ALZC_ZONE_OFFICE           3'h3
`define ALZC_ZONE_INDOOR           3'h4
`define ALZC_ZONE_DARK             3'h5

// ==========================================================================
// Scale of levels 2 and 3 against the sensor code (left shift)
`define ALZC_L2_SHIFT              1
`define ALZC_L3_SHIFT              0

`endif

/* src/alzc_cmp.v */
// One zone comparator with threshold and hysteresis
`timescale 1ns/100ps
module alzc_cmp #(
   parameter SENSE_W = 9,
   parameter SHIFT   = 0
) (
   // Clock and reset
   input  wire               ref_clk_i,
   input  wire               rst_n_i,
   // Settings
   input  wire               enable_i,
   input  wire [7:0]         threshold_i,
   input  wire [7:0]         hysteresis_i,
   // Sensor result
   input  wire [SENSE_W-1:0] sense_i,
   input  wire               sense_valid_i,
   // Result
   output wire               trip_o
);

   // =======================================================================
   // Threshold scaling
   wire [8:0]         release_code;
   wire [SENSE_W+1:0] low_lim;
   wire [SENSE_W+1:0] high_lim;
   wire [SENSE_W+1:0] sense_ext;
   reg                trip_ff;
   reg                nxt_trip;

   assign release_code = {1'b0, threshold_i} + {1'b0, hysteresis_i};
   assign low_lim   = {{(SENSE_W+2-8){1'b0}}, threshold_i} << SHIFT;
   assign high_lim  = {{(SENSE_W+2-9){1'b0}}, release_code} << SHIFT;
   assign sense_ext = {2'b00, sense_i};

   // =======================================================================
   // Trip state
   always @* begin
      nxt_trip = trip_ff;
      if (!enable_i) begin
         nxt_trip = 1'b0;
      end else if (sense_valid_i) begin
         if (sense_ext < low_lim) begin
            nxt_trip = 1'b1;
         end else if (sense_ext > high_lim) begin
            nxt_trip = 1'b0;
         end
      end
   end

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trip_ff <= 1'b0;
      end else begin
         trip_ff <= nxt_trip;
      end
   end

   assign trip_o = trip_ff;

endmodule

/* src/alzc_top.v */
// Ambient light zone comparator for the second light sensor
`timescale 1ns/100ps
`include "alzc_map.vh"
module alzc_top #(
   parameter SENSE_W = 9
) (
   // Clock and reset
   input  wire               ref_clk_i,
   input  wire               rst_n_i,
   // Register port
   input  wire [7:0]         reg_addr_i,
   input  wire               reg_wr_i,
   input  wire               reg_rd_i,
   input  wire [7:0]         reg_wdata_i,
   output wire [7:0]         reg_rdata_o,
   output wire               reg_rvalid_o,
   // Filtered sensor result, 2.16 uA per code
   input  wire [SENSE_W-1:0] sense_code_i,
   input  wire               sense_valid_i,
   // Level 4 and 5 comparator outputs from the outer levels
   input  wire               indoor_trip_i,
   input  wire               dark_trip_i,
   // Zone results
   output wire [3:0]         level_enable_o,
   output wire [2:0]         zone_o
);

   // =======================================================================
   // Address decode
   function [5:0] addr_hit;
      input [7:0] a;
      begin
         addr_hit = 6'h00;
         if (a == `ALZC_ADDR_LEVEL_ENABLE) begin
            addr_hit = 6'h01;
         end else if (a == `ALZC_ADDR_ZONE_STATUS) begin
            addr_hit = 6'h02;
         end else if (a == `ALZC_ADDR_L2_THRESHOLD) begin
            addr_hit = 6'h04;
         end else if (a == `ALZC_ADDR_L2_HYSTERESIS) begin
            addr_hit = 6'h08;
         end else if (a == `ALZC_ADDR_L3_THRESHOLD) begin
            addr_hit = 6'h10;
         end else if (a == `ALZC_ADDR_L3_HYSTERESIS) begin
            addr_hit = 6'h20;
         end
      end
   endfunction

   wire [5:0] wr_hit;
   wire [5:0] rd_hit;

   assign wr_hit = reg_wr_i ? addr_hit(reg_addr_i) : 6'h00;
   assign rd_hit = reg_rd_i ? addr_hit(reg_addr_i) : 6'h00;

   // =======================================================================
   // Settings registers
   reg [3:0] level_enable_ff;
   reg [7:0] l2_threshold_ff;
   reg [7:0] l2_hysteresis_ff;
   reg [7:0] l3_threshold_ff;
   reg [7:0] l3_hysteresis_ff;

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_enable_ff  <= `ALZC_RST_ENABLE;
         l2_threshold_ff  <= `ALZC_RST_BYTE;
         l2_hysteresis_ff <= `ALZC_RST_BYTE;
         l3_threshold_ff  <= `ALZC_RST_BYTE;
         l3_hysteresis_ff <= `ALZC_RST_BYTE;
      end else begin
         if (wr_hit[0]) begin
            level_enable_ff <= reg_wdata_i[`ALZC_ENABLE_MSB:0];
         end
         if (wr_hit[2]) begin
            l2_threshold_ff <= reg_wdata_i;
         end
         if (wr_hit[3]) begin
            l2_hysteresis_ff <= reg_wdata_i;
         end
         if (wr_hit[4]) begin
            l3_threshold_ff <= reg_wdata_i;
         end
         if (wr_hit[5]) begin
            l3_hysteresis_ff <= reg_wdata_i;
         end
      end
   end

   assign level_enable_o = level_enable_ff;

   // =======================================================================
   // Comparators
   wire bright_trip;
   wire office_trip;

   alzc_cmp #(
      .SENSE_W (SENSE_W),
      .SHIFT   (`ALZC_L2_SHIFT)
   ) u_cmp_l2 (
      .ref_clk_i     (ref_clk_i),
      .rst_n_i       (rst_n_i),
      .enable_i      (level_enable_ff[`ALZC_BIT_L2]),
      .threshold_i   (l2_threshold_ff),
      .hysteresis_i  (l2_hysteresis_ff),
      .sense_i       (sense_code_i),
      .sense_valid_i (sense_valid_i),
      .trip_o        (bright_trip)
   );

   alzc_cmp #(
      .SENSE_W (SENSE_W),
      .SHIFT   (`ALZC_L3_SHIFT)
   ) u_cmp_l3 (
      .ref_clk_i     (ref_clk_i),
      .rst_n_i       (rst_n_i),
      .enable_i      (level_enable_ff[`ALZC_BIT_L3]),
      .threshold_i   (l3_threshold_ff),
      .hysteresis_i  (l3_hysteresis_ff),
      .sense_i       (sense_code_i),
      .sense_valid_i (sense_valid_i),
      .trip_o        (office_trip)
   );

   // =======================================================================
   // Outer levels, sampled with each new result
   reg  [1:0] outer_trip_ff;
   reg  [1:0] nxt_outer_trip;

   always @* begin
      nxt_outer_trip = outer_trip_ff;
      if (sense_valid_i) begin
         nxt_outer_trip = {dark_trip_i, indoor_trip_i};
      end
      if (!level_enable_ff[`ALZC_BIT_L4]) begin
         nxt_outer_trip[0] = 1'b0;
      end
      if (!level_enable_ff[`ALZC_BIT_L5]) begin
         nxt_outer_trip[1] = 1'b0;
      end
   end

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         outer_trip_ff <= 2'b00;
      end else begin
         outer_trip_ff <= nxt_outer_trip;
      end
   end

   // =======================================================================
   // Status flags and zone
   wire       second_sensor_bright_flag;
   wire       second_sensor_office_flag;
   wire       second_sensor_indoor_flag;
   wire       second_sensor_dark_flag;
   wire [3:0] zone_flags;
   reg  [2:0] zone_ff;
   reg  [2:0] nxt_zone;

   assign second_sensor_bright_flag = bright_trip;
   assign second_sensor_office_flag = office_trip;
   assign second_sensor_indoor_flag = outer_trip_ff[0];
   assign second_sensor_dark_flag   = outer_trip_ff[1];

   assign zone_flags = {second_sensor_dark_flag,
                        second_sensor_indoor_flag,
                        second_sensor_office_flag,
                        second_sensor_bright_flag};

   always @* begin
      // Darkest tripped level wins
      if (zone_flags[`ALZC_BIT_L5]) begin
         nxt_zone = `ALZC_ZONE_DARK;
      end else if (zone_flags[`ALZC_BIT_L4]) begin
         nxt_zone = `ALZC_ZONE_INDOOR;
      end else if (zone_flags[`ALZC_BIT_L3]) begin
         nxt_zone = `ALZC_ZONE_OFFICE;
      end else if (zone_flags[`ALZC_BIT_L2]) begin
         nxt_zone = `ALZC_ZONE_BRIGHT;
      end else begin
         nxt_zone = `ALZC_ZONE_DAYLIGHT;
      end
   end

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         zone_ff <= `ALZC_ZONE_DAYLIGHT;
      end else begin
         zone_ff <= nxt_zone;
      end
   end

   assign zone_o = zone_ff;

   // =======================================================================
   // Read data
   reg [7:0] rdata_ff;
   reg       rvalid_ff;
   reg [7:0] nxt_rdata;

   always @* begin
      nxt_rdata = 8'h00;
      if (rd_hit[0]) begin
         nxt_rdata = {4'h0, level_enable_ff};
      end else if (rd_hit[1]) begin
         nxt_rdata = {4'h0, zone_flags};
      end else if (rd_hit[2]) begin
         nxt_rdata = l2_threshold_ff;
      end else if (rd_hit[3]) begin
         nxt_rdata = l2_hysteresis_ff;
      end else if (rd_hit[4]) begin
         nxt_rdata = l3_threshold_ff;
      end else if (rd_hit[5]) begin
         nxt_rdata = l3_hysteresis_ff;
      end
   end

   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff  <= `ALZC_RST_BYTE;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= reg_rd_i;
      end
   end

   assign reg_rdata_o  = rdata_ff;
   assign reg_rvalid_o = rvalid_ff;

endmodule

/* verification/alzc_sense_model.sv */
// Filtered sensor result source
`timescale 1ns/100ps
module alzc_sense_model (
   // Clock
   input  logic       ref_clk_i,
   // Result
   output logic [8:0] sense_code_o,
   output logic       sense_valid_o
);
   initial begin
      sense_code_o = 9'h000;
      sense_valid_o = 1'b0;
   end
   task send(input [8:0] c);
      begin
         @(negedge ref_clk_i);
         sense_code_o = c;
         sense_valid_o = 1'b1;
         @(negedge ref_clk_i);
         sense_valid_o = 1'b0;
         // Stale code must not look valid
         sense_code_o = ~c;
      end
   endtask
endmodule

/* verification/alzc_top_monitor.sv */
// Port checker for the light zone comparator
`timescale 1ns/100ps
module alzc_top_chk #(
   parameter SENSE_W = 9
) (
   // Clock and reset
   input logic               ref_clk_i,
   input logic               rst_n_i,
   // Register port
   input logic [7:0]         reg_addr_i,
   input logic               reg_wr_i,
   input logic               reg_rd_i,
   input logic [7:0]         reg_wdata_i,
   input logic [7:0]         reg_rdata_o,
   input logic               reg_rvalid_o,
   // Sensor and zone
   input logic [SENSE_W-1:0] sense_code_i,
   input logic               sense_valid_i,
   input logic               indoor_trip_i,
   input logic               dark_trip_i,
   input logic [3:0]         level_enable_o,
   input logic [2:0]         zone_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // ========================================================================
   // Register port
   chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read strobe without answer");
   chk_answer_idle: assert property (
      !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
      else $error("read answer without strobe");
   chk_unmapped_zero: assert property (
      reg_rd_i && reg_addr_i > 8'h35 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_status_reserved: assert property (
      reg_rd_i && reg_addr_i == 8'h31 |=> reg_rdata_o[7:4] == 4'h0)
      else $error("status reserved bits set");
   chk_status_zone: assert property (
      reg_rd_i && reg_addr_i == 8'h31 |=>
         zone_o == (reg_rdata_o[3] ? 3'h5 : reg_rdata_o[2] ? 3'h4 :
                    reg_rdata_o[1] ? 3'h3 : reg_rdata_o[0] ? 3'h2 : 3'h1))
      else $error("zone disagrees with status flags");
   chk_enable_readback: assert property (
      reg_rd_i && reg_addr_i == 8'h2f |=>
         reg_rdata_o == {4'h0, $past(level_enable_o)})
      else $error("enable readback wrong");
   chk_enable_hold: assert property (
      !(reg_wr_i && reg_addr_i == 8'h2f) |=> $stable(level_enable_o))
      else $error("enable changed without write");
   // ========================================================================
   // Zones
   chk_zone_range: assert property (zone_o >= 3'h1 && zone_o <= 3'h5)
      else $error("zone code out of range");
   chk_zone_disabled: assert property (
      (level_enable_o == 4'h0) [*3] |=> zone_o == 3'h1)
      else $error("zone left daylight while disabled");
   chk_zone_quiet: assert property (
      (!sense_valid_i && $stable(level_enable_o)) [*3] |=> $stable(zone_o))
      else $error("zone moved without new result");
   cov_bright: cover property (zone_o == 3'h2);
   cov_office: cover property (zone_o == 3'h3);
   cov_dark: cover property (zone_o == 3'h5);
endmodule
bind alzc_top alzc_top_chk #(.SENSE_W(SENSE_W)) chk_u (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .sense_code_i(sense_code_i), .sense_valid_i(sense_valid_i),
   .indoor_trip_i(indoor_trip_i), .dark_trip_i(dark_trip_i),
   .level_enable_o(level_enable_o), .zone_o(zone_o));

/* verification/ambient_light_zone_compare_bench.sv */
// Self-checking bench for the light zone comparator
`timescale 1ns/100ps
module ambient_light_zone_compare_bench;
   logic       ref_clk;
   logic       rst_n;
   logic [7:0] addr;
   logic       wr;
   logic       rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       rvalid;
   logic [8:0] code;
   logic       valid;
   logic       indoor;
   logic       dark;
   logic [3:0] en;
   logic [2:0] zone;
   int         errors = 0;
   int         cmp_count = 0;
   always #5 ref_clk = ~ref_clk;
   alzc_sense_model sense_u (.ref_clk_i(ref_clk), .sense_code_o(code),
      .sense_valid_o(valid));
   alzc_top #(.SENSE_W(9)) dut_u (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .sense_code_i(code),
      .sense_valid_i(valid), .indoor_trip_i(indoor), .dark_trip_i(dark),
      .level_enable_o(en), .zone_o(zone));
   // ========================================================================
   // Helpers
   task chk_byte(input [7:0] got, input [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task chk_zone(input [2:0] got, input [2:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t zone %h expected %h", $time, got, exp);
      end
   endtask
   task wr_reg(input [7:0] a, input [7:0] d);
      @(negedge ref_clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge ref_clk);
      wr = 1'b0;
   endtask
   task rd_reg(input [7:0] a, input [7:0] e);
      @(negedge ref_clk);
      addr = a;
      rd = 1'b1;
      @(negedge ref_clk);
      rd = 1'b0;
      chk_byte(rdata, e);
      chk_byte({7'h00, rvalid}, 8'h01);
   endtask
   task stop_test;
      $display("Checks %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ========================================================================
   // Scenarios
   task t_regs;
      chk_zone(zone, 3'h1);
      rd_reg(8'h2f, 8'h00);
      rd_reg(8'h40, 8'h00);
      wr_reg(8'h31, 8'hff);
      rd_reg(8'h31, 8'h00);
      wr_reg(8'h2f, 8'hff);
      rd_reg(8'h2f, 8'h0f);
      chk_byte({4'h0, en}, 8'h0f);
      wr_reg(8'h32, 8'hf0);
      rd_reg(8'h32, 8'hf0);
      wr_reg(8'h33, 8'h0a);
      rd_reg(8'h33, 8'h0a);
      wr_reg(8'h34, 8'hff);
      rd_reg(8'h34, 8'hff);
   endtask
   task t_level2;
      wr_reg(8'h2f, 8'h01);
      wr_reg(8'h32, 8'h0a);
      wr_reg(8'h33, 8'h05);
      sense_u.send(9'h014);
      rd_reg(8'h31, 8'h00);
      sense_u.send(9'h013);
      rd_reg(8'h31, 8'h01);
      chk_zone(zone, 3'h2);
      sense_u.send(9'h01e);
      rd_reg(8'h31, 8'h01);
      sense_u.send(9'h01f);
      rd_reg(8'h31, 8'h00);
      chk_zone(zone, 3'h1);
   endtask
   task t_level3;
      wr_reg(8'h2f, 8'h03);
      wr_reg(8'h34, 8'h08);
      wr_reg(8'h35, 8'h04);
      sense_u.send(9'h007);
      rd_reg(8'h31, 8'h03);
      chk_zone(zone, 3'h3);
      sense_u.send(9'h00c);
      rd_reg(8'h31, 8'h03);
      sense_u.send(9'h00d);
      rd_reg(8'h31, 8'h01);
      chk_zone(zone, 3'h2);
   endtask
   task t_outer;
      indoor = 1'b1;
      dark = 1'b1;
      wr_reg(8'h2f, 8'h0f);
      rd_reg(8'h31, 8'h01);
      sense_u.send(9'h007);
      rd_reg(8'h31, 8'h0f);
      chk_zone(zone, 3'h5);
      wr_reg(8'h2f, 8'h00);
      rd_reg(8'h31, 8'h00);
      chk_zone(zone, 3'h1);
   endtask
   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
      indoor = 1'b0;
      dark = 1'b0;
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      @(negedge ref_clk);
      t_regs;
      t_level2;
      t_level3;
      t_outer;
      stop_test;
   end
   initial begin
      #20000;
      errors++;
      stop_test;
   end
endmodule
